// ===== hdl/card_cmd_pkg.sv
// constants for the status report and transparent read command block
package card_cmd_pkg;
  // ****************************************
  // command codes and parameters
  // ****************************************
  localparam logic [7:0] INS_STATUS = 8'hf2;
  localparam logic [7:0] INS_READ = 8'hb0;
  localparam logic [7:0] MODE_FULL = 8'h00;
  localparam logic [7:0] MODE_NAME = 8'h01;
  localparam logic [7:0] MODE_NONE = 8'h0c;
  // ****************************************
  // status bytes
  // ****************************************
  localparam logic [7:0] SW_OK1 = 8'h90;
  localparam logic [7:0] SW_OK2 = 8'h00;
  localparam logic [7:0] SW_ERR69 = 8'h69;
  localparam logic [7:0] SW_SEC2 = 8'h82;
  localparam logic [7:0] SW_STRUCT2 = 8'h81;
  localparam logic [7:0] SW_PAR1 = 8'h6a;
  localparam logic [7:0] SW_PAR2 = 8'h86;
  localparam logic [7:0] SW_NOAPP2 = 8'h82;
  localparam logic [7:0] SW_NOFILE2 = 8'h82;
  localparam logic [7:0] SW_INS1 = 8'h6d;
  // ****************************************
  // template tags and values
  // ****************************************
  localparam logic [7:0] TAG_TPL = 8'h62;
  localparam logic [7:0] TAG_DESC = 8'h82;
  localparam logic [7:0] TAG_FID = 8'h83;
  localparam logic [7:0] TAG_NAME = 8'h84;
  localparam logic [7:0] TAG_PROP = 8'ha5;
  localparam logic [7:0] TAG_CHAR = 8'h80;
  localparam logic [7:0] TAG_LIFE = 8'h8a;
  localparam logic [7:0] TAG_SEC = 8'h8c;
  localparam logic [7:0] TAG_PINT = 8'hc6;
  localparam logic [7:0] TAG_PSO = 8'h90;
  localparam logic [7:0] DESC_DIR = 8'h38;
  localparam logic [7:0] DESC_APP = 8'h78;
  localparam logic [7:0] ROOT_HI = 8'h3f;
  localparam logic [7:0] ROOT_LO = 8'h00;
  localparam logic [7:0] LIFE_OP = 8'h05;
  localparam logic [7:0] CHAR_VAL = 8'h71;
  localparam logic [7:0] SEC_VAL = 8'h00;
  localparam logic [7:0] PSO_VAL = 8'h00;
  // ****************************************
  // file store geometry
  // ****************************************
  localparam int APP_ID_LEN = 7;
  localparam int TPL_MAX = 32;
  localparam int MEM_AW = 10;
  localparam int FILE_AW = 8;
  localparam logic [MEM_AW-1:0] MEM_FILE_BASE = 10'h000;
  localparam logic [7:0] SIZE_ZERO = 8'h00;
  localparam logic [4:0] SHORT_REF_NONE = 5'h00;
endpackage : card_cmd_pkg

// ===== hdl/card_status_and_binary_read.sv
// status report and transparent read command interpreter
`timescale 1ns/1ps
module card_status_and_binary_read (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_ins,
  input wire logic [7:0] first_parameter,
  input wire logic [7:0] second_parameter,
  input wire logic [7:0] cmd_len,
  input wire logic [4:0] short_file_ref,
  input wire logic sel_valid,
  input wire logic sel_is_dir,
  input wire logic sel_is_app,
  input wire logic [15:0] sel_fid,
  input wire logic [7:0] sel_file_base,
  input wire logic [7:0] sel_file_size,
  input wire logic sel_transparent,
  input wire logic sel_read_open,
  input wire logic [card_cmd_pkg::APP_ID_LEN*8-1:0] sel_app_id,
  input wire logic pin_verified,
  input wire logic short_ref_hit,
  input wire logic [7:0] short_ref_base,
  input wire logic short_ref_transparent,
  input wire logic short_ref_read_open,
  input wire logic load_en,
  input wire logic [card_cmd_pkg::MEM_AW-1:0] load_addr,
  input wire logic [7:0] load_data,
  output logic busy,
  output logic resp_valid,
  output logic [7:0] resp_data,
  output logic sw_valid,
  output logic [7:0] status_byte_one,
  output logic [7:0] status_byte_two
);
  // ****************************************
  // state
  // ****************************************
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_TPL = 5'b00010,
    ST_READ = 5'b00100,
    ST_DRAIN = 5'b01000,
    ST_SW = 5'b10000
  } state_e;

  typedef struct packed {
    state_e state;
    logic dir_is_app;
    logic [15:0] dir_fid;
    logic app_active;
    logic [card_cmd_pkg::APP_ID_LEN*8-1:0] app_id;
    logic [card_cmd_pkg::APP_ID_LEN*8-1:0] dir_app_id;
    logic [7:0] idx;
    logic [7:0] tpl_len;
    logic tpl_name_only;
    logic [card_cmd_pkg::MEM_AW-1:0] rd_ptr;
    logic [7:0] remain;
    logic rd_pend;
    logic busy;
    logic resp_valid;
    logic [7:0] resp_data;
    logic sw_valid;
    logic [7:0] sw1;
    logic [7:0] sw2;
    logic [7:0] sw1_hold;
    logic [7:0] sw2_hold;
  } state_s;

  state_s cur;
  state_s next_cur;
  logic [7:0] mem_q;
  typedef logic [card_cmd_pkg::MEM_AW-1:0] mem_aw_t;

  file_store u_store (
    .ref_clk(ref_clk),
    .wr_en(load_en),
    .wr_addr(load_addr),
    .wr_data(load_data),
    .rd_addr(cur.rd_ptr),
    .rd_data(mem_q)
  );

  // ****************************************
  // template byte generator
  // ****************************************
  function automatic logic [7:0] id_byte(input logic [card_cmd_pkg::APP_ID_LEN*8-1:0] id,
                                         input int k);
    id_byte = id[(card_cmd_pkg::APP_ID_LEN-1-k)*8 +: 8];
  endfunction : id_byte

  logic [7:0] tb [0:card_cmd_pkg::TPL_MAX-1];
  logic [7:0] tpl_n;
  always_comb begin
    int p;
    p = 0;
    for (int i = 0; i < card_cmd_pkg::TPL_MAX; i++) begin
      tb[i] = 8'h00;
    end
    if (cur.tpl_name_only) begin
      tb[0] = card_cmd_pkg::TAG_NAME;
      tb[1] = 8'(card_cmd_pkg::APP_ID_LEN);
      for (int k = 0; k < card_cmd_pkg::APP_ID_LEN; k++) begin
        tb[2+k] = id_byte(cur.app_id, k);
      end
      p = 2 + card_cmd_pkg::APP_ID_LEN;
    end else begin
      tb[0] = card_cmd_pkg::TAG_TPL;
      tb[2] = card_cmd_pkg::TAG_DESC;
      tb[3] = 8'h02;
      tb[4] = cur.dir_is_app ? card_cmd_pkg::DESC_APP : card_cmd_pkg::DESC_DIR;
      tb[5] = 8'h21;
      p = 6;
      if (cur.dir_is_app) begin
        tb[p] = card_cmd_pkg::TAG_NAME;
        tb[p+1] = 8'(card_cmd_pkg::APP_ID_LEN);
        for (int k = 0; k < card_cmd_pkg::APP_ID_LEN; k++) begin
          tb[p+2+k] = id_byte(cur.dir_app_id, k);
        end
        p = p + 2 + card_cmd_pkg::APP_ID_LEN;
      end else begin
        tb[p] = card_cmd_pkg::TAG_FID;
        tb[p+1] = 8'h02;
        tb[p+2] = cur.dir_fid[15:8];
        tb[p+3] = cur.dir_fid[7:0];
        p = p + 4;
        if (cur.dir_fid == {card_cmd_pkg::ROOT_HI, card_cmd_pkg::ROOT_LO}) begin
          tb[p] = card_cmd_pkg::TAG_PROP;
          tb[p+1] = 8'h03;
          tb[p+2] = card_cmd_pkg::TAG_CHAR;
          tb[p+3] = 8'h01;
          tb[p+4] = card_cmd_pkg::CHAR_VAL;
          p = p + 5;
        end
      end
      tb[p] = card_cmd_pkg::TAG_LIFE;
      tb[p+1] = 8'h01;
      tb[p+2] = card_cmd_pkg::LIFE_OP;
      tb[p+3] = card_cmd_pkg::TAG_SEC;
      tb[p+4] = 8'h01;
      tb[p+5] = card_cmd_pkg::SEC_VAL;
      tb[p+6] = card_cmd_pkg::TAG_PINT;
      tb[p+7] = 8'h03;
      tb[p+8] = card_cmd_pkg::TAG_PSO;
      tb[p+9] = 8'h01;
      tb[p+10] = card_cmd_pkg::PSO_VAL;
      p = p + 11;
      tb[1] = 8'(p - 2);
    end
    tpl_n = 8'(p);
  end

  // ****************************************
  // command sequencing
  // ****************************************
  always_comb begin
    next_cur = cur;
    next_cur.resp_valid = 1'b0;
    next_cur.sw_valid = 1'b0;
    next_cur.rd_pend = 1'b0;
    case (cur.state)
      ST_IDLE: begin
        next_cur.busy = 1'b0;
        if (sel_valid && sel_is_dir) begin
          next_cur.dir_is_app = sel_is_app;
          next_cur.dir_fid = sel_fid;
          next_cur.dir_app_id = sel_app_id;
          if (sel_is_app) begin
            next_cur.app_active = 1'b1;
            next_cur.app_id = sel_app_id;
          end
        end
        if (cmd_valid) begin
          next_cur.busy = 1'b1;
          next_cur.state = ST_SW;
          next_cur.sw1_hold = card_cmd_pkg::SW_OK1;
          next_cur.sw2_hold = card_cmd_pkg::SW_OK2;
          next_cur.idx = 8'h00;
          if (cmd_ins == card_cmd_pkg::INS_STATUS) begin
            case (second_parameter)
              card_cmd_pkg::MODE_FULL: begin
                next_cur.tpl_name_only = 1'b0;
                next_cur.state = ST_TPL;
              end
              card_cmd_pkg::MODE_NAME: begin
                if (cur.app_active) begin
                  next_cur.tpl_name_only = 1'b1;
                  next_cur.state = ST_TPL;
                end else begin
                  next_cur.sw1_hold = card_cmd_pkg::SW_PAR1;
                  next_cur.sw2_hold = card_cmd_pkg::SW_NOAPP2;
                end
              end
              card_cmd_pkg::MODE_NONE: begin
                next_cur.state = ST_SW;
              end
              default: begin
                next_cur.sw1_hold = card_cmd_pkg::SW_PAR1;
                next_cur.sw2_hold = card_cmd_pkg::SW_PAR2;
              end
            endcase
          end else if (cmd_ins == card_cmd_pkg::INS_READ) begin
            if (first_parameter[7] && short_file_ref != card_cmd_pkg::SHORT_REF_NONE) begin
              if (!short_ref_hit) begin
                next_cur.sw1_hold = card_cmd_pkg::SW_PAR1;
                next_cur.sw2_hold = card_cmd_pkg::SW_NOFILE2;
              end else if (!short_ref_transparent) begin
                next_cur.sw1_hold = card_cmd_pkg::SW_ERR69;
                next_cur.sw2_hold = card_cmd_pkg::SW_STRUCT2;
              end else if (!(short_ref_read_open || pin_verified)) begin
                next_cur.sw1_hold = card_cmd_pkg::SW_ERR69;
                next_cur.sw2_hold = card_cmd_pkg::SW_SEC2;
              end else begin
                next_cur.rd_ptr = mem_aw_t'({short_ref_base, 2'b00})
                                  + mem_aw_t'(second_parameter);
                next_cur.remain = cmd_len;
                next_cur.state = ST_READ;
              end
            end else if (!sel_transparent) begin
              next_cur.sw1_hold = card_cmd_pkg::SW_ERR69;
              next_cur.sw2_hold = card_cmd_pkg::SW_STRUCT2;
            end else if (!(sel_read_open || pin_verified)) begin
              next_cur.sw1_hold = card_cmd_pkg::SW_ERR69;
              next_cur.sw2_hold = card_cmd_pkg::SW_SEC2;
            end else begin
              next_cur.rd_ptr = mem_aw_t'({sel_file_base, 2'b00})
                + mem_aw_t'({first_parameter[1:0], second_parameter});
              next_cur.remain = cmd_len;
              next_cur.state = ST_READ;
            end
          end else begin
            next_cur.sw1_hold = card_cmd_pkg::SW_INS1;
            next_cur.sw2_hold = card_cmd_pkg::SW_OK2;
          end
        end
      end
      ST_TPL: begin
        next_cur.resp_valid = 1'b1;
        next_cur.resp_data = tb[cur.idx[4:0]];
        next_cur.idx = cur.idx + 8'h01;
        if (cur.idx + 8'h01 == tpl_n) begin
          next_cur.state = ST_SW;
        end
      end
      ST_READ: begin
        if (cur.remain == card_cmd_pkg::SIZE_ZERO) begin
          next_cur.state = ST_DRAIN;
        end else begin
          next_cur.rd_pend = 1'b1;
          next_cur.rd_ptr = cur.rd_ptr + 10'h001;
          next_cur.remain = cur.remain - 8'h01;
        end
        if (cur.rd_pend) begin
          next_cur.resp_valid = 1'b1;
          next_cur.resp_data = mem_q;
        end
      end
      ST_DRAIN: begin
        if (cur.rd_pend) begin
          next_cur.resp_valid = 1'b1;
          next_cur.resp_data = mem_q;
        end
        next_cur.state = ST_SW;
      end
      ST_SW: begin
        next_cur.sw_valid = 1'b1;
        next_cur.sw1 = cur.sw1_hold;
        next_cur.sw2 = cur.sw2_hold;
        next_cur.busy = 1'b0;
        next_cur.state = ST_IDLE;
      end
      default: begin
        next_cur.state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cur <= '0;
      cur.state <= ST_IDLE;
      cur.dir_fid <= {card_cmd_pkg::ROOT_HI, card_cmd_pkg::ROOT_LO};
    end else begin
      cur <= next_cur;
    end
  end

  assign busy = cur.busy;
  assign resp_valid = cur.resp_valid;
  assign resp_data = cur.resp_data;
  assign sw_valid = cur.sw_valid;
  assign status_byte_one = cur.sw1;
  assign status_byte_two = cur.sw2;
endmodule : card_status_and_binary_read

// ===== hdl/file_store.sv
// byte store for elementary file contents with registered read data
`timescale 1ns/1ps
module file_store (
  input wire logic ref_clk,
  input wire logic wr_en,
  input wire logic [card_cmd_pkg::MEM_AW-1:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic [card_cmd_pkg::MEM_AW-1:0] rd_addr,
  output logic [7:0] rd_data
);
  logic [7:0] mem [0:(1<<card_cmd_pkg::MEM_AW)-1];
  always_ff @(posedge ref_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule : file_store

// ===== testbench/card_cmd_props.sv
// property checker for the status and read command block
`timescale 1ns/1ps
module card_cmd_props (
  input logic ref_clk,
  input logic rst_n,
  input logic cmd_valid,
  input logic [7:0] cmd_ins,
  input logic [7:0] first_parameter,
  input logic [7:0] second_parameter,
  input logic sel_transparent,
  input logic sel_read_open,
  input logic pin_verified,
  input logic busy,
  input logic resp_valid,
  input logic [7:0] resp_data,
  input logic sw_valid,
  input logic [7:0] status_byte_one,
  input logic [7:0] status_byte_two
);
  // ****************************************
  // command decode and assertions
  // ****************************************
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic st, rd, bad;
  assign st = cmd_valid && !busy && cmd_ins == card_cmd_pkg::INS_STATUS;
  assign rd = cmd_valid && !busy && cmd_ins == card_cmd_pkg::INS_READ && !first_parameter[7];
  assign bad = st && !(second_parameter inside {8'h00, 8'h01, 8'h0c});
  a_sw_single: assert property (sw_valid |=> !sw_valid)
    else $error("status strobe longer than one cycle");
  a_none_ok: assert property (st && second_parameter == 8'h0c |->
    ##[1:8] (sw_valid && status_byte_one == 8'h90 && status_byte_two == 8'h00))
    else $error("status only request not answered 90 00");
  a_none_nodata: assert property (st && second_parameter == 8'h0c |=> !resp_valid [*3])
    else $error("status only request returned data");
  a_bad_mode: assert property (bad |-> ##[1:8] (sw_valid
    && status_byte_one == card_cmd_pkg::SW_PAR1 && status_byte_two == card_cmd_pkg::SW_PAR2))
    else $error("unknown mode not rejected");
  a_bad_nodata: assert property (bad |=> !resp_valid [*3])
    else $error("unknown mode returned data");
  a_read_locked: assert property (rd && sel_transparent && !sel_read_open && !pin_verified |->
    ##[1:8] (sw_valid && status_byte_one == 8'h69 && status_byte_two == 8'h82))
    else $error("locked read not refused");
  a_read_struct: assert property (rd && !sel_transparent && pin_verified |->
    ##[1:8] (sw_valid && status_byte_one == 8'h69 && status_byte_two == 8'h81))
    else $error("structured file read not aborted");
  a_tpl_start: assert property (st && second_parameter == 8'h00 |->
    ##[1:4] (resp_valid && resp_data == card_cmd_pkg::TAG_TPL))
    else $error("template does not open with its tag");
  a_resp_busy: assert property (resp_valid |-> busy)
    else $error("data byte outside a command");
endmodule : card_cmd_props
bind card_status_and_binary_read card_cmd_props u_props (.ref_clk, .rst_n, .cmd_valid,
  .cmd_ins, .first_parameter, .second_parameter, .sel_transparent, .sel_read_open,
  .pin_verified, .busy, .resp_valid, .resp_data, .sw_valid, .status_byte_one,
  .status_byte_two);

// ===== testbench/card_status_and_binary_read_bench.sv
// self-checking bench for the status and read command block
`timescale 1ns/1ps
module card_status_and_binary_read_bench;
  // ****************************************
  // signals, notes and tasks
  // ****************************************
  logic ref_clk = 0, rst_n = 0, cmd_valid, busy, resp_valid, sw_valid, sel_valid, sel_is_dir;
  logic sel_is_app, sel_transparent, sel_read_open, pin_verified, short_ref_hit;
  logic short_ref_transparent, short_ref_read_open, load_en;
  logic [7:0] cmd_ins, first_parameter, second_parameter, cmd_len, sel_file_base, sel_file_size;
  logic [7:0] short_ref_base, load_data, resp_data, status_byte_one, status_byte_two, p;
  logic [4:0] short_file_ref;
  logic [15:0] sel_fid;
  logic [55:0] sel_app_id, app_id;
  logic [card_cmd_pkg::MEM_AW-1:0] load_addr;
  typedef struct packed {logic [7:0] n, s1, s2;} note_s;
  note_s notes[$];
  logic [7:0] exp_b[$], cap[$], last[$];
  logic [7:0] img [11] = '{8'ha1, 8'ha2, 8'ha3, 8'ha4, 8'ha5, 8'ha6, 8'ha7, 8'ha8, 8'ha9, 0, 0};
  int n_fail = 0, n_tests = 0;
  always #12.5 ref_clk = ~ref_clk;
  card_status_and_binary_read u_dut (.ref_clk, .rst_n, .cmd_valid, .cmd_ins,
    .first_parameter, .second_parameter, .cmd_len, .short_file_ref, .sel_valid,
    .sel_is_dir, .sel_is_app, .sel_fid, .sel_file_base, .sel_file_size, .sel_transparent,
    .sel_read_open, .sel_app_id, .pin_verified, .short_ref_hit, .short_ref_base,
    .short_ref_transparent, .short_ref_read_open, .load_en, .load_addr, .load_data, .busy,
    .resp_valid, .resp_data, .sw_valid, .status_byte_one, .status_byte_two);
  terminal_model u_term (.ref_clk, .sw_valid, .cmd_valid, .cmd_ins, .first_parameter,
    .second_parameter, .cmd_len, .short_file_ref);
  task chk8(input string w, input logic [7:0] e, g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", w, e, g);
    end
  endtask : chk8
  always @(posedge ref_clk) begin
    if (resp_valid === 1'b1) begin
      cap.push_back(resp_data);
      if (exp_b.size() > 0) chk8("read byte", exp_b.pop_front(), resp_data);
    end
    if (sw_valid === 1'b1 && notes.size() > 0) begin
      if (notes[0].n != 8'hff) chk8("byte count", notes[0].n, 8'(cap.size()));
      chk8("status one", notes[0].s1, status_byte_one);
      chk8("status two", notes[0].s2, status_byte_two);
      last = cap;
      cap = {};
      notes.delete(0);
    end
  end
  task run(input logic [7:0] ins, p1, p2, ln, n, s1, s2, input logic [4:0] sf);
    notes.push_back('{n, s1, s2});
    u_term.send(ins, p1, p2, ln, sf);
    @(posedge ref_clk);
    chk8("unanswered commands", 8'h00, 8'(notes.size()));
    notes = {};
  endtask : run
  task stat(input logic [7:0] p2, n, s1, s2);
    run(card_cmd_pkg::INS_STATUS, 8'h00, p2, 8'h00, n, s1, s2, 5'h00);
  endtask : stat
  task rdx(input logic [7:0] p1, p2, ln, s2, input logic [4:0] sf);
    int o;
    o = p1[7] ? int'(p2) : int'({p1, p2});
    if (s2 == 8'h00) for (int i = 0; i < ln; i++) exp_b.push_back(img[o + i]);
    run(card_cmd_pkg::INS_READ, p1, p2, ln, (s2 == 0) ? ln : 8'h00, (s2 == 0) ? 8'h90 : 8'h69,
      s2, sf);
  endtask : rdx
  task tpl(input int st, input logic [15:0] fid, input logic [7:0] m);
    int i, l, ns;
    logic [7:0] seen;
    i = st;
    ns = 0;
    seen = 0;
    while (i + 1 < last.size()) begin
      l = last[i + 1];
      case (last[i])
        8'h82: seen[0] = last[i + 2] inside {8'h38, 8'h78};
        8'h83: seen[1] = {last[i + 2], last[i + 3]} == fid;
        8'h84: begin
          seen[2] = l == 7;
          for (int k = 0; k < 7; k++) if (last[i + 2 + k] !== app_id[(6 - k) * 8 +: 8]) seen[2] = 0;
        end
        8'ha5: seen[3] = last[i + 2] == 8'h80;
        8'h8a: seen[4] = 1;
        8'hc6: seen[5] = last[i + 2] == 8'h90;
        8'h8c, 8'hab, 8'h8b: ns++;
        default: ;
      endcase
      i += 2 + l;
    end
    chk8("template objects", m, seen & m);
    if (st == 2) chk8("template tag", card_cmd_pkg::TAG_TPL, last[0]);
    if (st == 2) chk8("security objects", 8'h01, 8'(ns));
  endtask : tpl
  task sel(input logic dir, app, input logic [15:0] fid, input logic [7:0] b, input logic tr);
    @(posedge ref_clk);
    {sel_valid, sel_is_dir, sel_is_app, sel_fid, sel_file_base, sel_transparent} <=
      {1'b1, dir, app, fid, b, tr};
    sel_app_id <= app ? app_id : {$urandom, 24'h0};
    @(posedge ref_clk);
    sel_valid <= 0;
  endtask : sel
  task end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_sim
  initial begin
    #(500us);
    n_fail++;
    $display("watchdog expired");
    end_sim;
  end
  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    void'($urandom(5004));
    {sel_valid, sel_is_dir, sel_is_app, sel_fid, sel_file_base, sel_transparent} = '0;
    {sel_read_open, pin_verified, short_ref_hit, short_ref_transparent} = '0;
    {short_ref_read_open, load_en} = '0;
    {sel_file_size, short_ref_base, load_data, load_addr, sel_app_id} = {8'h0b, 8'h04, 74'h0};
    app_id = 56'({$urandom, $urandom});
    repeat (6) @(posedge ref_clk);
    rst_n <= 1;
    for (int i = 0; i < 11; i++) begin
      @(posedge ref_clk);
      {load_en, load_addr, load_data} <= {1'b1, 10'(16 + i), img[i]};
    end
    @(posedge ref_clk);
    load_en <= 0;
    stat(8'h00, 8'hff, 8'h90, 8'h00);
    tpl(2, 16'h3f00, 8'h3b);
    stat(8'h01, 0, card_cmd_pkg::SW_PAR1, card_cmd_pkg::SW_NOAPP2);
    stat(8'h0c, 0, 8'h90, 8'h00);
    for (int i = 0; i < 3; i++) begin
      p = 8'($urandom) | 8'h10;
      stat(p, 0, card_cmd_pkg::SW_PAR1, card_cmd_pkg::SW_PAR2);
    end
    $display("status modes done");
    sel(1, 1, 16'h7fff, 0, 0);
    stat(8'h00, 8'hff, 8'h90, 8'h00);
    tpl(2, 0, 8'h35);
    sel(1, 0, 16'h7f10, 0, 0);
    stat(8'h01, 8'hff, 8'h90, 8'h00);
    tpl(0, 0, 8'h04);
    stat(8'h00, 8'hff, 8'h90, 8'h00);
    tpl(2, 16'h7f10, 8'h33);
    $display("application report done");
    sel(0, 0, 16'h6f7e, 8'h04, 1);
    rdx(0, 0, 11, 8'h82, 0);
    pin_verified <= 1;
    rdx(0, 0, 11, 8'h00, 0);
    rdx(0, 0, 1, 8'h00, 0);
    rdx(0, 1, 10, 8'h00, 0);
    for (int i = 0; i < 4; i++) begin
      p = 8'($urandom % 11);
      rdx(0, p, 8'(1 + $urandom % (11 - p)), 8'h00, 0);
    end
    $display("transparent read done");
    sel(0, 0, 16'h6f08, 8'h10, 1);
    {short_ref_hit, short_ref_transparent, short_ref_read_open} <= 3'b111;
    rdx(8'h80, 0, 11, 8'h00, 5'(1 + $urandom % 30));
    sel(0, 0, 16'h2f00, 8'h20, 0);
    rdx(0, 0, 1, 8'h81, 0);
    $display("short reference and structure done");
    end_sim;
  end
endmodule : card_status_and_binary_read_bench

// ===== testbench/terminal_model.sv
// terminal model that issues one command and waits for its answer
`timescale 1ns/1ps
module terminal_model (
  input logic ref_clk,
  input logic sw_valid,
  output logic cmd_valid,
  output logic [7:0] cmd_ins,
  output logic [7:0] first_parameter,
  output logic [7:0] second_parameter,
  output logic [7:0] cmd_len,
  output logic [4:0] short_file_ref
);
  // ****************************************
  // command issue
  // ****************************************
  initial {cmd_valid, cmd_ins, first_parameter, second_parameter, cmd_len, short_file_ref} = '0;
  task send(input logic [7:0] ins, p1, p2, ln, input logic [4:0] sf);
    @(posedge ref_clk);
    cmd_valid <= 1'b1;
    {cmd_ins, first_parameter, second_parameter, cmd_len, short_file_ref} <= {ins, p1, p2, ln, sf};
    @(posedge ref_clk);
    cmd_valid <= 1'b0;
    {cmd_ins, first_parameter, second_parameter, cmd_len} <= ~{ins, p1, p2, ln};
    repeat (300) begin
      @(posedge ref_clk);
      if (sw_valid === 1'b1) break;
    end
  endtask : send
endmodule : terminal_model
